// >>> rtl/scan_port_regs.vh
// scan port constants: state codes, instruction codes, register widths
// assumes inclusion by the scan port design files only
`ifndef SCAN_PORT_REGS_VH
`define SCAN_PORT_REGS_VH

// ----------------------------------------
// tap state codes
// ----------------------------------------
`define ST_TLR 4'h0
`define ST_RTI 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PAU_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PAU_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UPD_IR 4'hf

// ----------------------------------------
// instruction register
// ----------------------------------------
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define IR_BYPASS 4'hf
`define IR_EMU_CTRL 4'h8
`define IR_IDCODE 4'he

// ----------------------------------------
// emulator control data register fields
// ----------------------------------------
`define EMU_WIDTH 4
`define EMU_A_OE_BIT 0
`define EMU_A_VAL_BIT 1
`define EMU_B_OE_BIT 2
`define EMU_B_VAL_BIT 3
`define EMU_RESET 4'h0

// ----------------------------------------
// identity register width
// ----------------------------------------
`define ID_WIDTH 32

`endif

// >>> rtl/pin_sync.v
// two-stage synchroniser for a bundle of pin levels
// assumes the inputs are asynchronous to clock
`timescale 1ns/1ps
module pin_sync
#(
    parameter WIDTH = 1
)
(
    // clock
    input wire clock,
    // levels
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

reg [WIDTH-1:0] meta;

// first stage read only by the second
always @(posedge clock)
begin
    meta <= din;
    dout <= meta;
end

endmodule

// >>> rtl/tap_fsm.v
// sixteen-state test access port sequencer
// assumes step is a one-cycle pulse on each rising scan clock edge
`timescale 1ns/1ps
`include "scan_port_regs.vh"
module tap_fsm
(
    // clock and reset
    input wire clock,
    input wire hold_reset,
    // stepping
    input wire step,
    input wire mode,
    output reg [3:0] state
);

reg [3:0] next_state;

always @*
begin
    next_state = state;
    case (state)
        `ST_TLR: next_state = mode ? `ST_TLR : `ST_RTI;
        `ST_RTI: next_state = mode ? `ST_SEL_DR : `ST_RTI;
        `ST_SEL_DR: next_state = mode ? `ST_SEL_IR : `ST_CAP_DR;
        `ST_CAP_DR: next_state = mode ? `ST_EX1_DR : `ST_SH_DR;
        `ST_SH_DR: next_state = mode ? `ST_EX1_DR : `ST_SH_DR;
        `ST_EX1_DR: next_state = mode ? `ST_UPD_DR : `ST_PAU_DR;
        `ST_PAU_DR: next_state = mode ? `ST_EX2_DR : `ST_PAU_DR;
        `ST_EX2_DR: next_state = mode ? `ST_UPD_DR : `ST_SH_DR;
        `ST_UPD_DR: next_state = mode ? `ST_SEL_DR : `ST_RTI;
        `ST_SEL_IR: next_state = mode ? `ST_TLR : `ST_CAP_IR;
        `ST_CAP_IR: next_state = mode ? `ST_EX1_IR : `ST_SH_IR;
        `ST_SH_IR: next_state = mode ? `ST_EX1_IR : `ST_SH_IR;
        `ST_EX1_IR: next_state = mode ? `ST_UPD_IR : `ST_PAU_IR;
        `ST_PAU_IR: next_state = mode ? `ST_EX2_IR : `ST_PAU_IR;
        `ST_EX2_IR: next_state = mode ? `ST_UPD_IR : `ST_SH_IR;
        default: next_state = mode ? `ST_SEL_DR : `ST_RTI;
    endcase
end

always @(posedge clock)
begin
    if (hold_reset)
        state <= `ST_TLR;
    else if (step)
        state <= next_state;
end

endmodule

// >>> rtl/scan_test_emulation_port.v
// scan test access port with emulator event pins and output disable
// assumes scan pins are asynchronous; the scan clock is sampled by CLOCK
// and must stay well below half its rate
`timescale 1ns/1ps
`include "scan_port_regs.vh"

// How it works
// - sample mode and data on rising scan edge
// - scan output changes only on falling edge
// - scan output floats unless shifting
// - output disable low floats scan output
// - test reset high enables scan control
// - test reset low ignores scan activity
// - pin a bidirectional, direction set by scan
// - pin b bidirectional, direction set by scan
// - test reset low makes pin b disable
// - disable floats every device output driver
module scan_test_emulation_port
#(
    parameter [31:0] ID_VALUE = 32'h00000001
)
(
    // clock and reset
    input wire CLOCK,
    input wire SRST,
    // scan pins
    input wire SCAN_CLK,
    input wire SCAN_MODE,
    input wire SCAN_DIN,
    input wire SCAN_RESET,
    output reg SCAN_DOUT,
    output wire SCAN_DOUT_OE,
    // emulator event pin a
    input wire EMULATOR_EVENT_PIN_A_IN,
    output wire EMULATOR_EVENT_PIN_A_OUT,
    output wire EMULATOR_EVENT_PIN_A_OE,
    // emulator event pin b or output disable
    input wire EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN,
    output wire EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT,
    output wire EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE,
    // to the rest of the device
    output wire OUTPUTS_DISABLE,
    output wire SCAN_ACTIVE,
    output reg EMU_EVENT_A,
    output reg EMU_EVENT_B,
    input wire EMU_SIGNAL_A,
    input wire EMU_SIGNAL_B
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
wire [5:0] sync_in;
wire [5:0] sync_out;
wire tck;
wire tms;
wire tdi;
wire trst;
wire pin_a;
wire pin_b;

assign sync_in = {EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN, EMULATOR_EVENT_PIN_A_IN,
                  SCAN_RESET, SCAN_DIN, SCAN_MODE, SCAN_CLK};

pin_sync #(.WIDTH(6)) u_sync
(
    .clock(CLOCK),
    .din(sync_in),
    .dout(sync_out)
);

assign tck = sync_out[0];
assign tms = sync_out[1];
assign tdi = sync_out[2];
assign trst = sync_out[3];
assign pin_a = sync_out[4];
assign pin_b = sync_out[5];

// ----------------------------------------
// scan clock edges
// ----------------------------------------
reg tck_d;
wire rise;
wire fall;

always @(posedge CLOCK)
begin
    if (SRST)
        tck_d <= 1'b0;
    else
        tck_d <= tck;
end

// edges count only while test reset high
assign rise = trst && tck && !tck_d;
assign fall = trst && !tck && tck_d;

// ----------------------------------------
// tap sequencer
// ----------------------------------------
wire [3:0] state;
wire hold_reset;

// test reset low pins the sequencer
assign hold_reset = SRST || !trst;

tap_fsm u_fsm
(
    .clock(CLOCK),
    .hold_reset(hold_reset),
    .step(rise),
    .mode(tms),
    .state(state)
);

// ----------------------------------------
// instruction and data registers
// ----------------------------------------
reg [`IR_WIDTH-1:0] ir_shift;
reg [`IR_WIDTH-1:0] ir;
reg bypass;
reg [`ID_WIDTH-1:0] id_shift;
reg [`EMU_WIDTH-1:0] emu_shift;
reg [`EMU_WIDTH-1:0] emu_ctrl;

// ----------------------------------------
// instruction decode
// ----------------------------------------
reg sel_id;
reg sel_emu;

// anything unlisted takes the one-bit bypass path
always @*
begin
    sel_id = 1'b0;
    sel_emu = 1'b0;
    if (ir == `IR_IDCODE)
        sel_id = 1'b1;
    else if (ir == `IR_EMU_CTRL)
        sel_emu = 1'b1;
end

// ----------------------------------------
// scan captures
// ----------------------------------------
// all scan captures on rising edge
always @(posedge CLOCK)
begin
    if (hold_reset)
    begin
        ir_shift <= `IR_CAPTURE;
        ir <= `IR_IDCODE;
        bypass <= 1'b0;
        id_shift <= {`ID_WIDTH{1'b0}};
        emu_shift <= `EMU_RESET;
        emu_ctrl <= `EMU_RESET;
    end
    else if (rise)
    begin
        case (state)
            `ST_CAP_IR: ir_shift <= `IR_CAPTURE;
            `ST_SH_IR: ir_shift <= {tdi, ir_shift[`IR_WIDTH-1:1]};
            `ST_UPD_IR: ir <= ir_shift;
            `ST_CAP_DR:
            begin
                bypass <= 1'b0;
                id_shift <= ID_VALUE;
                emu_shift <= emu_ctrl;
            end
            `ST_SH_DR:
            begin
                bypass <= tdi;
                id_shift <= {tdi, id_shift[`ID_WIDTH-1:1]};
                emu_shift <= {tdi, emu_shift[`EMU_WIDTH-1:1]};
            end
            `ST_UPD_DR:
            begin
                // direction of pin a set by scan
                // direction of pin b set by scan
                if (sel_emu)
                    emu_ctrl <= emu_shift;
            end
            default:
            begin
                bypass <= bypass;
            end
        endcase
    end
end

// ----------------------------------------
// serial output
// ----------------------------------------
reg shifting;
wire disable_cond;

function sel_bit;
    input [3:0] st;
    input use_id;
    input use_emu;
    input irb;
    input idb;
    input emb;
    input byb;
    begin
        if (st == `ST_SH_IR)
            sel_bit = irb;
        else if (use_id)
            sel_bit = idb;
        else if (use_emu)
            sel_bit = emb;
        else
            sel_bit = byb;
    end
endfunction

// output and enable move on falling edge
always @(posedge CLOCK)
begin
    if (hold_reset)
    begin
        SCAN_DOUT <= 1'b0;
        shifting <= 1'b0;
    end
    else if (fall)
    begin
        SCAN_DOUT <= sel_bit(state, sel_id, sel_emu, ir_shift[0], id_shift[0],
                             emu_shift[0], bypass);
        shifting <= (state == `ST_SH_IR) || (state == `ST_SH_DR);
    end
end

// pin b reads as disable while test reset low
// host supplies reset low, pin a high
assign disable_cond = !trst && pin_a && !pin_b;

assign OUTPUTS_DISABLE = disable_cond;
assign SCAN_ACTIVE = trst;

// ----------------------------------------
// pin drive decode
// ----------------------------------------
// one rule for every enable that leaves the block
function drive_on;
    input scan_on;
    input wanted;
    input off;
    begin
        drive_on = scan_on && wanted && !off;
    end
endfunction

// an input pin only reports while scan owns it
function heard;
    input scan_on;
    input driving;
    input level;
    begin
        heard = scan_on && !driving && level;
    end
endfunction

// test reset gates it
// shifting clears a cycle after test reset drops
assign SCAN_DOUT_OE = drive_on(trst, shifting, disable_cond);

// ----------------------------------------
// emulator event pins
// ----------------------------------------
reg pin_a_out;
reg pin_b_out;

// pin a drives only when configured as output
assign EMULATOR_EVENT_PIN_A_OE = drive_on(trst, emu_ctrl[`EMU_A_OE_BIT], disable_cond);
assign EMULATOR_EVENT_PIN_A_OUT = pin_a_out;
// pin b drives only when configured as output
// pin b is the disable input itself, never gated by it
assign EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE = drive_on(trst, emu_ctrl[`EMU_B_OE_BIT], 1'b0);
assign EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT = pin_b_out;

// data levels leave from flops, one cycle behind their sources
always @(posedge CLOCK)
begin
    if (SRST)
    begin
        pin_a_out <= 1'b0;
        pin_b_out <= 1'b0;
        EMU_EVENT_A <= 1'b0;
        EMU_EVENT_B <= 1'b0;
    end
    else
    begin
        pin_a_out <= emu_ctrl[`EMU_A_VAL_BIT] | EMU_SIGNAL_A;
        pin_b_out <= emu_ctrl[`EMU_B_VAL_BIT] | EMU_SIGNAL_B;
        // event inputs only mean something in scan mode
        EMU_EVENT_A <= heard(trst, emu_ctrl[`EMU_A_OE_BIT], pin_a);
        EMU_EVENT_B <= heard(trst, emu_ctrl[`EMU_B_OE_BIT], pin_b);
    end
end

endmodule

// >>> verif/scan_port_sva.sv
// checker for the scan port top module
// assumes bind by port names onto the design top
`timescale 1ns/1ps
module scan_port_sva (
    input logic CLOCK, SRST, SCAN_CLK, SCAN_RESET, SCAN_DOUT, SCAN_DOUT_OE,
    input logic EMULATOR_EVENT_PIN_A_IN, EMULATOR_EVENT_PIN_A_OUT, EMULATOR_EVENT_PIN_A_OE,
    input logic EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN,
    input logic EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE,
    input logic OUTPUTS_DISABLE, SCAN_ACTIVE, EMU_SIGNAL_A
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    wire off_in = !SCAN_RESET && EMULATOR_EVENT_PIN_A_IN
        && !EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN;
    a_dout_on_fall:
        assert property ($changed(SCAN_DOUT) |-> !SCAN_CLK) else $error("dout moved high");
    a_oe_when_active:
        assert property (SCAN_DOUT_OE |-> SCAN_ACTIVE) else $error("dout driven idle");
    a_off_floats:
        assert property (OUTPUTS_DISABLE |-> !SCAN_DOUT_OE && !EMULATOR_EVENT_PIN_A_OE)
        else $error("driver on while off");
    a_off_enters:
        assert property (off_in [*4] |=> OUTPUTS_DISABLE) else $error("off not taken");
    a_off_leaves:
        assert property (!off_in [*4] |=> !OUTPUTS_DISABLE) else $error("off stuck");
    a_scan_takes:
        assert property (SCAN_RESET [*3] |=> SCAN_ACTIVE) else $error("scan not active");
    a_scan_drops:
        assert property (!SCAN_RESET [*3] |=> !SCAN_ACTIVE) else $error("scan still active");
    a_pin_a_dir:
        assert property (EMULATOR_EVENT_PIN_A_OE |-> SCAN_ACTIVE && !OUTPUTS_DISABLE)
        else $error("pin a driven");
    a_pin_b_role:
        assert property (EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE |-> SCAN_ACTIVE)
        else $error("pin b driven");
    a_pin_a_level:
        assert property ((EMULATOR_EVENT_PIN_A_OE && EMU_SIGNAL_A) [*2] |->
        EMULATOR_EVENT_PIN_A_OUT) else $error("pin a level");
endmodule
bind scan_test_emulation_port scan_port_sva chk (
    .CLOCK(CLOCK),
    .SRST(SRST),
    .SCAN_CLK(SCAN_CLK),
    .SCAN_RESET(SCAN_RESET),
    .SCAN_DOUT(SCAN_DOUT),
    .SCAN_DOUT_OE(SCAN_DOUT_OE),
    .EMULATOR_EVENT_PIN_A_IN(EMULATOR_EVENT_PIN_A_IN),
    .EMULATOR_EVENT_PIN_A_OUT(EMULATOR_EVENT_PIN_A_OUT),
    .EMULATOR_EVENT_PIN_A_OE(EMULATOR_EVENT_PIN_A_OE),
    .EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN(EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN),
    .EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE(EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE),
    .OUTPUTS_DISABLE(OUTPUTS_DISABLE),
    .SCAN_ACTIVE(SCAN_ACTIVE),
    .EMU_SIGNAL_A(EMU_SIGNAL_A)
);

// >>> verif/scan_host_model.sv
// tester model: scan clock, mode, data, test reset, pin levels
// assumes tasks are called from the bench top
`timescale 1ns/1ps
module scan_host_model (
    input logic CLOCK, SCAN_DOUT, SCAN_DOUT_OE,
    input logic EMULATOR_EVENT_PIN_A_OUT, EMULATOR_EVENT_PIN_A_OE,
    input logic EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT,
    input logic EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE,
    output logic SCAN_CLK, SCAN_MODE, SCAN_DIN, SCAN_RESET,
    output logic EMULATOR_EVENT_PIN_A_IN, EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN
);
    logic lvl_a = 1'h0;
    logic lvl_b = 1'h1;
    initial
    begin
        SCAN_CLK = 1'h0;
        SCAN_MODE = 1'h1;
        SCAN_DIN = 1'h1;
        SCAN_RESET = 1'h0;
    end
    assign EMULATOR_EVENT_PIN_A_IN = EMULATOR_EVENT_PIN_A_OE ? EMULATOR_EVENT_PIN_A_OUT : lvl_a;
    assign EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN = EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE ?
        EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT : lvl_b;
    // one scan step
    // clock stands low between frames; read dout at the rise
    task tick(input logic m, input logic d, output logic q, output logic oe);
        @(posedge CLOCK);
        SCAN_MODE <= m;
        SCAN_DIN <= d;
        repeat (3) @(posedge CLOCK);
        q = SCAN_DOUT;
        oe = SCAN_DOUT_OE;
        SCAN_CLK <= 1'h1;
        repeat (4) @(posedge CLOCK);
        SCAN_CLK <= 1'h0;
    endtask
endmodule

// >>> verif/scan_test_emulation_port_tb.sv
// bench for the scan port with a tester model
// assumes the host model drives every scan pin
`timescale 1ns/1ps
module scan_test_emulation_port_tb;
    logic CLOCK, SRST, EMU_SIGNAL_A, EMU_SIGNAL_B;
    wire SCAN_CLK, SCAN_MODE, SCAN_DIN, SCAN_RESET, SCAN_DOUT, SCAN_DOUT_OE;
    wire EMULATOR_EVENT_PIN_A_IN, EMULATOR_EVENT_PIN_A_OUT, EMULATOR_EVENT_PIN_A_OE;
    wire EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_IN, EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT;
    wire EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE;
    wire OUTPUTS_DISABLE, SCAN_ACTIVE, EMU_EVENT_A, EMU_EVENT_B;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    scan_test_emulation_port dut (.*);
    scan_host_model host (.*);
    always #50 CLOCK = ~CLOCK;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task finish_test;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    // hang guard, runs need well under this
    always @(posedge CLOCK)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test;
        end
    end
    task automatic scan(input logic ir, input logic [3:0] v, output logic [3:0] got);
        logic q, oe;
        host.tick(1'h1, 1'h1, q, oe);
        if (ir)
            host.tick(1'h1, 1'h1, q, oe);
        host.tick(1'h0, 1'h1, q, oe);
        host.tick(1'h0, 1'h1, q, oe);
        for (int i = 0; i < 4; i++)
        begin
            host.tick(i == 3, v[i], q, oe);
            got[i] = q;
            chk(oe, 4'h1);
        end
        host.tick(1'h1, 1'h1, q, oe);
        chk(oe, 4'h0);
        host.tick(1'h0, 1'h1, q, oe);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_func;
        logic q, oe;
        logic [4:0] walk = 5'h02;
        host.lvl_a <= 1'h1;
        repeat (6) @(posedge CLOCK);
        chk(OUTPUTS_DISABLE, 4'h0);
        chk(SCAN_ACTIVE, 4'h0);
        for (int i = 0; i < 5; i++)
            host.tick(walk[i], 1'h0, q, oe);
        chk(oe, 4'h0);
        host.lvl_b <= 1'h0;
        repeat (6) @(posedge CLOCK);
        chk(OUTPUTS_DISABLE, 4'h1);
        chk(SCAN_DOUT_OE, 4'h0);
        host.lvl_a <= 1'h0;
        repeat (6) @(posedge CLOCK);
        chk(OUTPUTS_DISABLE, 4'h0);
        host.lvl_b <= 1'h1;
    endtask
    task automatic t_scan;
        logic q, oe;
        logic [3:0] got;
        host.SCAN_RESET <= 1'h1;
        repeat (6) @(posedge CLOCK);
        chk(SCAN_ACTIVE, 4'h1);
        chk(EMU_EVENT_A, 4'h0);
        chk(EMU_EVENT_B, 4'h1);
        host.lvl_a <= 1'h1;
        host.lvl_b <= 1'h0;
        repeat (4) @(posedge CLOCK);
        chk(EMU_EVENT_A, 4'h1);
        chk(EMU_EVENT_B, 4'h0);
        host.lvl_a <= 1'h0;
        host.lvl_b <= 1'h1;
        host.tick(1'h0, 1'h1, q, oe);
        scan(1'h1, 4'h8, got);
        chk(got, 4'h1);
        scan(1'h0, 4'h5, got);
        chk(got, 4'h0);
        chk(EMULATOR_EVENT_PIN_A_OE, 4'h1);
        chk(EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE, 4'h1);
        chk(EMULATOR_EVENT_PIN_A_OUT, 4'h0);
        EMU_SIGNAL_A <= 1'h1;
        EMU_SIGNAL_B <= 1'h1;
        repeat (4) @(posedge CLOCK);
        chk(EMU_EVENT_A, 4'h0);
        chk(EMULATOR_EVENT_PIN_A_OUT, 4'h1);
        chk(EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OUT, 4'h1);
        host.SCAN_RESET <= 1'h0;
        repeat (6) @(posedge CLOCK);
        chk(EMULATOR_EVENT_PIN_A_OE, 4'h0);
        chk(EMULATOR_EVENT_PIN_B_OR_OUTPUT_DISABLE_OE, 4'h0);
    endtask
    initial
    begin
        CLOCK = 1'h0;
        SRST = 1'h1;
        EMU_SIGNAL_A = 1'h0;
        EMU_SIGNAL_B = 1'h0;
        repeat (12) @(posedge CLOCK);
        SRST <= 1'h0;
        t_func;
        t_scan;
        finish_test;
    end
endmodule
